// File: rtl/fcp_defs.svh
/*
 * Constants of the framed command engine: frame layout, timing, limits,
 * reset values and the fixed answer values.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH

`define FCP_FRAME_BYTES 4'hc
`define FCP_LAST_BYTE 4'hb
`define FCP_CK_LSB 88
`define FCP_RSV_LSB 80
`define FCP_PAR_LSB 16
`define FCP_CLK_PERIOD_NS 25
`define FCP_BYTE_TIMEOUT_NS 1000000
`define FCP_TIMEOUT_CYCLES (`FCP_BYTE_TIMEOUT_NS / `FCP_CLK_PERIOD_NS)

`define FCP_ROM_WORDS 6'h20
`define FCP_SERIAL_BASE 5'h00
`define FCP_NAME_BASE 5'h10
`define FCP_SERIAL_LEN 64'h6
`define FCP_NAME_LEN 64'h9
`define FCP_CRC_INIT 16'hffff
`define FCP_CRC_POLY 16'h1021

// Identity and version values are arbitrary.
`define FCP_DEVICE_ID 64'h0000_0000_0000_0a5a
`define FCP_HW_VERSION 24'h01_00_00
`define FCP_SW_VERSION 24'h01_00_00
`define FCP_VOL_PER_STEP 64'h0

`define FCP_VOL_MIN 64'h0
`define FCP_VOL_MAX 64'hfff
`define FCP_PW_MIN 64'h1
`define FCP_PW_MAX 64'h7fff_ffff
`define FCP_RR_MIN 64'h1
`define FCP_RR_MAX 64'h7fff_ffff
`define FCP_SHOTS_MIN 64'h1
`define FCP_SHOTS_MAX 64'h7fff_ffff
`define FCP_OC_MIN 64'h0
`define FCP_OC_MAX 64'hfff
`define FCP_TEMP_MIN 16'h0000
`define FCP_TEMP_MAX 16'h0064
`define FCP_LSTAT_MAX 64'h7fff_ffff

`define FCP_VOL_RST 12'h000
`define FCP_PW_RST 32'h0000_0064
`define FCP_RR_RST 32'h0000_03e8
`define FCP_SHOTS_RST 32'h0000_0001
`define FCP_OC_RST 12'hfff
`define FCP_TEMP_RST 16'h0032
`define FCP_UMIN_RST 12'h000
`define FCP_LSTAT_RST 32'h0000_0000

`endif

// File: rtl/fcp_pkg.sv
/*
 * Types of the framed command engine: states, command and answer codes.
 * Assumes nothing of its surroundings.
 */
package fcp_pkg;

	typedef enum {ST_CRC, ST_RX, ST_DECODE, ST_ANSWER, ST_TX} fcp_state_t;

	typedef enum logic [15:0] {
		CMD_PING = 16'hfe01, CMD_IDENT = 16'hfe02, CMD_HW_VER = 16'hfe06,
		CMD_SW_VER = 16'hfe07, CMD_SERIAL = 16'hfe08, CMD_NAME = 16'hfe09,
		CMD_CRC = 16'hfe0a, CMD_RESET = 16'hfe0e, CMD_RESEND = 16'hff11,
		Q_CPU_TEMP = 16'h0001, Q_DEV_TEMP = 16'h0002, Q_VOL_MIN = 16'h0003,
		Q_VOL_MAX = 16'h0004, Q_VOL_SET = 16'h0005, Q_VOL_ACT = 16'h0006,
		Q_VOL_STEP = 16'h0007, Q_CUR_VAL = 16'h0008, Q_LSTAT = 16'h0009,
		Q_DEV_ID = 16'h000a, Q_PW = 16'h000b, Q_PW_MIN = 16'h000c,
		Q_PW_MAX = 16'h000d, Q_RR = 16'h000e, Q_RR_MIN = 16'h000f,
		Q_RR_MAX = 16'h0010, Q_SHOTS = 16'h0011, Q_SHOTS_MIN = 16'h0012,
		Q_SHOTS_MAX = 16'h0013, Q_OC = 16'h0014, Q_OC_MIN = 16'h0015,
		Q_OC_MAX = 16'h0016, Q_OC_VAL = 16'h0017, Q_TEMP_OFF = 16'h001b,
		Q_TEMP_MIN = 16'h001c, Q_TEMP_MAX = 16'h001d, Q_UMIN = 16'h001e,
		Q_ERROR = 16'h001f, Q_DEV_NAME = 16'h0022, S_VOL = 16'h0030,
		S_LSTAT = 16'h0031, S_RR = 16'h0032, S_PW = 16'h0033,
		S_SHOTS = 16'h0034, S_OC = 16'h0035, S_TEMP_OFF = 16'h0036,
		S_UMIN = 16'h0038, S_CLR_ERR = 16'h0039, S_CAL = 16'h003a,
		S_DEFAULTS = 16'h003c
	} fcp_cmd_t;

	typedef enum logic [15:0] {
		RSP_PING = 16'hff01, RSP_IDENT = 16'hff02, RSP_HW_VER = 16'hff06,
		RSP_SW_VER = 16'hff07, RSP_SERIAL = 16'hff08, RSP_NAME = 16'hff09,
		RSP_CRC = 16'hff0a, RSP_RESET = 16'hff0b, RSP_CKSUM_FAULT = 16'hff10,
		RSP_BAD_PARAM = 16'hff12, RSP_UNKNOWN = 16'hff13,
		RSP_TEMP = 16'h0050, RSP_UMIN = 16'h0051, RSP_CURRENT = 16'h0052,
		RSP_VOLTAGE = 16'h0053, RSP_LSTAT = 16'h0054, RSP_DEV_ID = 16'h0055,
		RSP_PW = 16'h0056, RSP_RR = 16'h0057, RSP_SHOTS = 16'h0058,
		RSP_ERROR = 16'h0059, RSP_CLR_ERR = 16'h005a, RSP_CAL = 16'h005b,
		RSP_DEV_NAME = 16'h005c, RSP_DEFAULTS = 16'h0060
	} fcp_rsp_t;

endpackage

// File: rtl/fcp_string_rom.sv
/*
 * Read-only store of the serial number and device name strings.
 * Assumes a synchronous reader: data appear one clock after the address.
 */
`timescale 1ns/100ps
`include "fcp_defs.svh"
module fcp_string_rom
	import fcp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [4:0] i_addr,
	output logic [7:0] o_data
);

	localparam int SER_LEN = 6;
	localparam int NAME_LEN = 9;
	localparam logic [8*SER_LEN-1:0] SER_TXT = "FC0001";
	localparam logic [8*NAME_LEN-1:0] NAME_TXT = "PULSECTRL";

	// The first character of each string sits at its base address.
	function automatic logic [7:0] rom_word(input logic [4:0] a);
		logic [7:0] b;
		int i;
		b = 8'h00;
		i = int'(a[3:0]);
		if (!a[4] && i < SER_LEN)
			b = SER_TXT[8*(SER_LEN-1-i) +: 8];
		else if (a[4] && i < NAME_LEN)
			b = NAME_TXT[8*(NAME_LEN-1-i) +: 8];
		return b;
	endfunction

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_data <= 8'h00;
		else
			o_data <= rom_word(i_addr);
	end

endmodule

// File: rtl/fcp_frame_engine.sv
/*
 * Framed command engine: takes 12-byte command frames, checks them,
 * executes the command against its own settings and answers with a frame.
 * Assumes byte streams on the same clock with valid/ready handshakes.
 */
// Behaviour
// - Frames are 12 contiguous bytes, gaps time out
// - Command and parameter travel least significant first
// - Eleventh byte reserved zero, twelfth is checksum
// - Checksum is XOR of first eleven bytes
// - Every received frame gets a full answer frame
// - Bad parameter answers with bad_parameter_reply
// - Unknown command answers with unknown_command_reply
// - Checksum mismatch answers checksum_fault_reply, no execution
// - Resend request repeats the most recent frame
// - Presence check reinitialises link, answers zero; here it only answers, no link state is reset
// - Identify returns device identifier, no state change
// - Versions answer major, minor, revision bytes
// - Serial query: zero gives length, else character
// - Name query works like the serial query
// - Memory query returns CRC16 over program memory
// - Software reset restores power-on state, acknowledged
// - Device queries and settings answer fixed codes
// - Out of range settings rejected, else echoed
`timescale 1ns/100ps
`include "fcp_defs.svh"
module fcp_frame_engine
	import fcp_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `FCP_TIMEOUT_CYCLES
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	input wire logic [15:0] i_cpu_temp,
	input wire logic [15:0] i_dev_temp,
	input wire logic [11:0] i_vol_act,
	input wire logic [31:0] i_cur_val,
	input wire logic [31:0] i_overcur_val,
	input wire logic [31:0] i_dev_id,
	input wire logic [31:0] i_err_set,
	output logic [11:0] o_vol_set,
	output logic [31:0] o_lstat,
	output logic [31:0] o_reprate,
	output logic [31:0] o_pulse_width,
	output logic [31:0] o_shots,
	output logic [11:0] o_overcur,
	output logic [15:0] o_temp_off,
	output logic [11:0] o_umin,
	output logic [31:0] o_err,
	output logic o_cal_start,
	output logic o_frame_drop
);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	function automatic logic [7:0] frame_xor(input logic [87:0] f);
		logic [7:0] x;
		x = 8'h00;
		for (int i = 0; i < 11; i++)
			x ^= f[i*8 +: 8];
		return x;
	endfunction

	function automatic logic [95:0] build_frame(input logic [15:0] c, input logic [63:0] p);
		return {frame_xor({8'h00, p, c}), 8'h00, p, c};
	endfunction

	function automatic logic in_range(input logic [63:0] v, input logic [63:0] lo,
		input logic [63:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ `FCP_CRC_POLY) : (r << 1);
		return r;
	endfunction

	fcp_state_t st_q;
	logic rx_accept;
	logic [3:0] rx_idx_q;
	wire [95:0] rx_buf;
	logic [31:0] gap_q;
	logic [15:0] rx_cmd;
	logic [63:0] rx_par;
	logic ck_bad;
	logic [95:0] tx_sr_q;
	logic [3:0] tx_cnt_q;
	logic [15:0] ans_cmd_q;
	logic [15:0] ans_cmd_d;
	logic [63:0] ans_par_q;
	logic [63:0] ans_par_d;
	logic par_bad;
	logic set_req;
	logic set_ok;
	logic soft_rst;
	logic rst_def;
	logic clr_err;
	logic cal_go;
	logic crc_pend_q;
	logic [5:0] crc_cnt_q;
	logic [15:0] crc_q;
	logic [15:0] crc_val_q;
	logic [4:0] rom_addr;
	logic [7:0] rom_data;
	logic [63:0] str_len;
	logic [63:0] str_val;
	logic str_bad;
	logic zp_bad;

	assign rx_accept = i_rx_valid && o_rx_ready;
	assign o_rx_ready = (st_q == ST_RX);
	assign o_tx_valid = (st_q == ST_TX);
	assign o_tx_data = tx_sr_q[7:0];
	assign rx_cmd = rx_buf[15:0];
	assign rx_par = rx_buf[`FCP_RSV_LSB-1:`FCP_PAR_LSB];
	assign ck_bad = frame_xor(rx_buf[87:0]) != rx_buf[`FCP_CK_LSB +: 8];
	assign zp_bad = (rx_par != 64'h0);

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			st_q <= ST_CRC;
		else
			case (st_q)
				ST_CRC: if (crc_cnt_q == `FCP_ROM_WORDS) st_q <= ST_RX;
				ST_RX: if (rx_accept && rx_idx_q == `FCP_LAST_BYTE) st_q <= ST_DECODE;
				ST_DECODE: st_q <= ST_ANSWER;
				ST_ANSWER: st_q <= ST_TX;
				ST_TX:
					if (i_tx_ready && tx_cnt_q == `FCP_LAST_BYTE)
						st_q <= crc_pend_q ? ST_CRC : ST_RX;
				default: st_q <= ST_RX;
			endcase
	end

	// Byte position and gap timer; a stalled frame is dropped whole.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rx_idx_q <= 4'h0;
			gap_q <= 32'h0;
			o_frame_drop <= 1'b0;
		end
		else
		begin
			o_frame_drop <= 1'b0;
			if (st_q != ST_RX)
			begin
				rx_idx_q <= 4'h0;
				gap_q <= 32'h0;
			end
			else if (rx_accept)
			begin
				rx_idx_q <= (rx_idx_q == `FCP_LAST_BYTE) ? 4'h0 : rx_idx_q + 4'h1;
				gap_q <= 32'h0;
			end
			else if (rx_idx_q != 4'h0)
			begin
				if (gap_q == 32'(TIMEOUT_CYCLES - 1))
				begin
					rx_idx_q <= 4'h0;
					gap_q <= 32'h0;
					o_frame_drop <= 1'b1;
				end
				else
					gap_q <= gap_q + 32'h1;
			end
		end
	end

	generate
		for (genvar g = 0; g < 12; g++)
		begin : g_rx_byte
			logic [7:0] byte_q;
			always_ff @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
					byte_q <= 8'h00;
				else if (rx_accept && rx_idx_q == 4'(g))
					byte_q <= i_rx_data;
			end
			assign rx_buf[g*8 +: 8] = byte_q;
		end
	endgenerate

	AST_TIMEOUT: assert property (
		(st_q == ST_RX && !rx_accept && rx_idx_q != 4'h0 && gap_q == 32'(TIMEOUT_CYCLES - 1))
		|=> (rx_idx_q == 4'h0) && o_frame_drop)
	else $error("stalled frame was not dropped");

	////////////////////////////////////////////////////////////////////////////

	// Program memory check, run after power-on and after a software reset.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			crc_cnt_q <= 6'h00;
			crc_q <= `FCP_CRC_INIT;
			crc_val_q <= 16'h0000;
		end
		else if (st_q != ST_CRC)
		begin
			crc_cnt_q <= 6'h00;
			crc_q <= `FCP_CRC_INIT;
		end
		else
		begin
			crc_cnt_q <= crc_cnt_q + 6'h01;
			if (crc_cnt_q != 6'h00)
				crc_q <= crc_step(crc_q, rom_data);
			if (crc_cnt_q == `FCP_ROM_WORDS)
				crc_val_q <= crc_step(crc_q, rom_data);
		end
	end

	always_comb
	begin
		if (st_q == ST_CRC)
			rom_addr = crc_cnt_q[4:0];
		else if (rx_cmd == CMD_SERIAL)
			rom_addr = `FCP_SERIAL_BASE + (rx_par[4:0] - 5'h01);
		else
			rom_addr = `FCP_NAME_BASE + (rx_par[4:0] - 5'h01);
	end

	fcp_string_rom u_rom (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_addr(rom_addr),
		.o_data(rom_data)
	);

	assign str_len = (rx_cmd == CMD_SERIAL) ? `FCP_SERIAL_LEN : `FCP_NAME_LEN;
	assign str_val = (rx_par == 64'h0) ? str_len : {56'h0, rom_data};
	assign str_bad = (rx_par > str_len);

	////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		{ans_cmd_d, ans_par_d} = {RSP_UNKNOWN, 64'h0};
		par_bad = 1'b0;
		set_req = 1'b0;
		soft_rst = 1'b0;
		rst_def = 1'b0;
		clr_err = 1'b0;
		cal_go = 1'b0;
		if (ck_bad)
			ans_cmd_d = RSP_CKSUM_FAULT;
		else
		begin
			case (rx_cmd)
				CMD_PING: {ans_cmd_d, par_bad} = {RSP_PING, zp_bad};
				CMD_IDENT: {ans_cmd_d, ans_par_d, par_bad} = {RSP_IDENT, `FCP_DEVICE_ID, zp_bad};
				CMD_HW_VER: {ans_cmd_d, ans_par_d, par_bad} =
					{RSP_HW_VER, 40'h0, `FCP_HW_VERSION, zp_bad};
				CMD_SW_VER: {ans_cmd_d, ans_par_d, par_bad} =
					{RSP_SW_VER, 40'h0, `FCP_SW_VERSION, zp_bad};
				CMD_SERIAL: {ans_cmd_d, ans_par_d, par_bad} = {RSP_SERIAL, str_val, str_bad};
				CMD_NAME: {ans_cmd_d, ans_par_d, par_bad} = {RSP_NAME, str_val, str_bad};
				Q_DEV_NAME: {ans_cmd_d, ans_par_d, par_bad} = {RSP_DEV_NAME, str_val, str_bad};
				CMD_CRC: {ans_cmd_d, ans_par_d, par_bad} = {RSP_CRC, 48'h0, crc_val_q, zp_bad};
				CMD_RESET:
				begin
					{ans_cmd_d, par_bad} = {RSP_RESET, zp_bad};
					soft_rst = !zp_bad;
				end
				CMD_RESEND: {ans_cmd_d, ans_par_d} = {ans_cmd_q, ans_par_q};
				Q_CPU_TEMP: {ans_cmd_d, ans_par_d} = {RSP_TEMP, {48{i_cpu_temp[15]}}, i_cpu_temp};
				Q_DEV_TEMP: {ans_cmd_d, ans_par_d} = {RSP_TEMP, {48{i_dev_temp[15]}}, i_dev_temp};
				Q_VOL_MIN: {ans_cmd_d, ans_par_d} = {RSP_VOLTAGE, `FCP_VOL_MIN};
				Q_VOL_MAX: {ans_cmd_d, ans_par_d} = {RSP_VOLTAGE, `FCP_VOL_MAX};
				Q_VOL_SET: {ans_cmd_d, ans_par_d} = {RSP_VOLTAGE, 52'h0, o_vol_set};
				Q_VOL_ACT: {ans_cmd_d, ans_par_d} = {RSP_VOLTAGE, 52'h0, i_vol_act};
				Q_VOL_STEP: {ans_cmd_d, ans_par_d} = {RSP_VOLTAGE, `FCP_VOL_PER_STEP};
				Q_CUR_VAL: {ans_cmd_d, ans_par_d} = {RSP_CURRENT, 32'h0, i_cur_val};
				Q_LSTAT: {ans_cmd_d, ans_par_d} = {RSP_LSTAT, 32'h0, o_lstat};
				Q_DEV_ID: {ans_cmd_d, ans_par_d} = {RSP_DEV_ID, 32'h0, i_dev_id};
				Q_PW: {ans_cmd_d, ans_par_d} = {RSP_PW, 32'h0, o_pulse_width};
				Q_PW_MIN: {ans_cmd_d, ans_par_d} = {RSP_PW, `FCP_PW_MIN};
				Q_PW_MAX: {ans_cmd_d, ans_par_d} = {RSP_PW, `FCP_PW_MAX};
				Q_RR: {ans_cmd_d, ans_par_d} = {RSP_RR, 32'h0, o_reprate};
				Q_RR_MIN: {ans_cmd_d, ans_par_d} = {RSP_RR, `FCP_RR_MIN};
				Q_RR_MAX: {ans_cmd_d, ans_par_d} = {RSP_RR, `FCP_RR_MAX};
				Q_SHOTS: {ans_cmd_d, ans_par_d} = {RSP_SHOTS, 32'h0, o_shots};
				Q_SHOTS_MIN: {ans_cmd_d, ans_par_d} = {RSP_SHOTS, `FCP_SHOTS_MIN};
				Q_SHOTS_MAX: {ans_cmd_d, ans_par_d} = {RSP_SHOTS, `FCP_SHOTS_MAX};
				Q_OC: {ans_cmd_d, ans_par_d} = {RSP_CURRENT, 52'h0, o_overcur};
				Q_OC_MIN: {ans_cmd_d, ans_par_d} = {RSP_CURRENT, `FCP_OC_MIN};
				Q_OC_MAX: {ans_cmd_d, ans_par_d} = {RSP_CURRENT, `FCP_OC_MAX};
				Q_OC_VAL: {ans_cmd_d, ans_par_d} = {RSP_CURRENT, 32'h0, i_overcur_val};
				Q_TEMP_OFF: {ans_cmd_d, ans_par_d} = {RSP_TEMP, {48{o_temp_off[15]}}, o_temp_off};
				Q_TEMP_MIN: {ans_cmd_d, ans_par_d} = {RSP_TEMP, 48'h0, `FCP_TEMP_MIN};
				Q_TEMP_MAX: {ans_cmd_d, ans_par_d} = {RSP_TEMP, 48'h0, `FCP_TEMP_MAX};
				Q_UMIN: {ans_cmd_d, ans_par_d} = {RSP_UMIN, 52'h0, o_umin};
				Q_ERROR: {ans_cmd_d, ans_par_d} = {RSP_ERROR, 32'h0, o_err};
				S_VOL: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_VOLTAGE, rx_par, 1'b1, !in_range(rx_par, `FCP_VOL_MIN, `FCP_VOL_MAX)};
				S_LSTAT: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_LSTAT, rx_par, 1'b1, !in_range(rx_par, 64'h0, `FCP_LSTAT_MAX)};
				S_RR: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_RR, rx_par, 1'b1, !in_range(rx_par, `FCP_RR_MIN, `FCP_RR_MAX)};
				S_PW: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_PW, rx_par, 1'b1, !in_range(rx_par, `FCP_PW_MIN, `FCP_PW_MAX)};
				S_SHOTS: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_SHOTS, rx_par, 1'b1, !in_range(rx_par, `FCP_SHOTS_MIN, `FCP_SHOTS_MAX)};
				S_OC: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_CURRENT, rx_par, 1'b1, !in_range(rx_par, `FCP_OC_MIN, `FCP_OC_MAX)};
				S_UMIN: {ans_cmd_d, ans_par_d, set_req, par_bad} =
					{RSP_VOLTAGE, rx_par, 1'b1, !in_range(rx_par, `FCP_VOL_MIN, `FCP_VOL_MAX)};
				S_TEMP_OFF:
				begin
					{ans_cmd_d, ans_par_d, set_req} = {RSP_TEMP, rx_par, 1'b1};
					par_bad = (rx_par[63:16] != 48'h0) ||
						($signed(rx_par[15:0]) < $signed(`FCP_TEMP_MIN)) ||
						($signed(rx_par[15:0]) > $signed(`FCP_TEMP_MAX));
				end
				S_CLR_ERR: {ans_cmd_d, par_bad, clr_err} = {RSP_CLR_ERR, zp_bad, !zp_bad};
				S_CAL: {ans_cmd_d, par_bad, cal_go} = {RSP_CAL, zp_bad, !zp_bad};
				S_DEFAULTS: {ans_cmd_d, par_bad, rst_def} = {RSP_DEFAULTS, zp_bad, !zp_bad};
				default: {ans_cmd_d, ans_par_d} = {RSP_UNKNOWN, 64'h0};
			endcase
			if (par_bad)
				{ans_cmd_d, ans_par_d} = {RSP_BAD_PARAM, 64'h0};
		end
	end

	assign set_ok = set_req && !par_bad && !ck_bad;

	////////////////////////////////////////////////////////////////////////////

	// Settings; a software reset or a defaults command restores reset values.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_vol_set <= `FCP_VOL_RST;
			o_lstat <= `FCP_LSTAT_RST;
			o_reprate <= `FCP_RR_RST;
			o_pulse_width <= `FCP_PW_RST;
			o_shots <= `FCP_SHOTS_RST;
			o_overcur <= `FCP_OC_RST;
			o_temp_off <= `FCP_TEMP_RST;
			o_umin <= `FCP_UMIN_RST;
		end
		else if (st_q == ST_ANSWER && !ck_bad && (soft_rst || rst_def))
		begin
			o_vol_set <= `FCP_VOL_RST;
			o_lstat <= `FCP_LSTAT_RST;
			o_reprate <= `FCP_RR_RST;
			o_pulse_width <= `FCP_PW_RST;
			o_shots <= `FCP_SHOTS_RST;
			o_overcur <= `FCP_OC_RST;
			o_temp_off <= `FCP_TEMP_RST;
			o_umin <= `FCP_UMIN_RST;
		end
		else if (st_q == ST_ANSWER && set_ok)
			case (rx_cmd)
				S_VOL: o_vol_set <= rx_par[11:0];
				S_LSTAT: o_lstat <= rx_par[31:0];
				S_RR: o_reprate <= rx_par[31:0];
				S_PW: o_pulse_width <= rx_par[31:0];
				S_SHOTS: o_shots <= rx_par[31:0];
				S_OC: o_overcur <= rx_par[11:0];
				S_TEMP_OFF: o_temp_off <= rx_par[15:0];
				S_UMIN: o_umin <= rx_par[11:0];
				default: o_umin <= o_umin;
			endcase
	end

	// Error bits are sticky; a new error in the clearing cycle survives.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_err <= 32'h0;
			o_cal_start <= 1'b0;
			crc_pend_q <= 1'b0;
		end
		else
		begin
			o_err <= (o_err & ~{32{st_q == ST_ANSWER && (clr_err || soft_rst)}}) | i_err_set;
			o_cal_start <= (st_q == ST_ANSWER) && cal_go;
			if (st_q == ST_ANSWER && soft_rst)
				crc_pend_q <= 1'b1;
			else if (st_q == ST_CRC)
				crc_pend_q <= 1'b0;
		end
	end

	// Answer frame: the last one is kept so a resend request can repeat it.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tx_sr_q <= 96'h0;
			tx_cnt_q <= 4'h0;
			ans_cmd_q <= 16'h0000;
			ans_par_q <= 64'h0;
		end
		else if (st_q == ST_ANSWER)
		begin
			tx_sr_q <= build_frame(ans_cmd_d, ans_par_d);
			tx_cnt_q <= 4'h0;
			ans_cmd_q <= ans_cmd_d;
			ans_par_q <= ans_par_d;
		end
		else if (st_q == ST_TX && i_tx_ready)
		begin
			tx_sr_q <= {8'h00, tx_sr_q[95:8]};
			tx_cnt_q <= tx_cnt_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	sequence s_frame_end;
		rx_accept && rx_idx_q == `FCP_LAST_BYTE;
	endsequence

	sequence s_good(logic [15:0] c);
		st_q == ST_ANSWER && !ck_bad && rx_cmd == c;
	endsequence

	AST_ANSWER_FOLLOWS: assert property (
		s_frame_end |-> ##3 o_tx_valid && o_tx_data == ans_cmd_q[7:0])
	else $error("no answer frame after a received frame");

	AST_TX_FORMAT: assert property (
		$rose(o_tx_valid) |-> tx_sr_q[87:80] == 8'h00 && tx_sr_q[95:88] == frame_xor(tx_sr_q[87:0]))
	else $error("answer frame reserved byte or checksum wrong");

	AST_TX_LEN: assert property (
		o_tx_valid && i_tx_ready && tx_cnt_q == `FCP_LAST_BYTE |=> !o_tx_valid)
	else $error("answer frame longer than twelve bytes");

	AST_CKSUM_FAULT: assert property (
		st_q == ST_ANSWER && ck_bad |=> tx_sr_q[15:0] == RSP_CKSUM_FAULT && $stable(o_vol_set))
	else $error("checksum fault not answered or command executed");

	AST_UNKNOWN: assert property (
		s_good(16'hfe03) |=> tx_sr_q[15:0] == RSP_UNKNOWN)
	else $error("unknown command not answered as such");

	AST_PING: assert property (
		s_good(CMD_PING) and rx_par == 64'h0 |=> tx_sr_q[79:0] == {64'h0, RSP_PING})
	else $error("presence check answer wrong");

	AST_HWVER: assert property (
		s_good(CMD_HW_VER) and rx_par == 64'h0
		|=> tx_sr_q[79:0] == {40'h0, `FCP_HW_VERSION, RSP_HW_VER})
	else $error("hardware version answer wrong");

	AST_VOL_SET: assert property (
		s_good(S_VOL) and rx_par <= `FCP_VOL_MAX
		|=> o_vol_set == rx_par[11:0] && tx_sr_q[79:16] == rx_par)
	else $error("voltage setting not applied or not echoed");

	AST_VOL_BAD: assert property (
		s_good(S_VOL) and rx_par > `FCP_VOL_MAX
		|=> tx_sr_q[15:0] == RSP_BAD_PARAM && $stable(o_vol_set))
	else $error("out of range voltage not rejected");

	AST_RESEND: assert property (
		s_good(CMD_RESEND) |=> tx_sr_q[79:0] == {$past(ans_par_q), $past(ans_cmd_q)})
	else $error("resend did not repeat the last answer");

	AST_RESET_ACK: assert property (
		s_good(CMD_RESET) and rx_par == 64'h0
		|=> tx_sr_q[15:0] == RSP_RESET && o_vol_set == `FCP_VOL_RST)
	else $error("software reset not acknowledged or not applied");

endmodule

// File: tb/fcp_host.sv
/*
 * Host model: sends command frames and takes the answer frames.
 * Assumes the engine's valid/ready byte links on the rising edge of i_clk.
 */
`timescale 1ns/100ps
module fcp_host
(
	input wire logic i_clk,
	output logic o_valid,
	output logic [7:0] o_data,
	input wire logic i_ready,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready
);
	logic [7:0] ans [12];
	initial
	begin
		o_valid = 1'b0;
		o_data = 8'h00;
		o_tx_ready = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic edge_wait(input bit tx);
		int t;
		t = 0;
		do
		begin
			@(posedge i_clk);
			t++;
		end
		while (((tx ? i_tx_valid : i_ready) !== 1'b1) && t < 300);
		if (t >= 300)
		begin
			testbench.errors++;
			testbench.report_and_stop();
		end
	endtask
	// Sends n bytes of a frame; a full frame is then answered and taken with one stall.
	task automatic xfer(input logic [15:0] c, input logic [63:0] p, input logic [7:0] flip,
		input int n);
		logic [95:0] f;
		f = {8'h00, 8'h00, p, c};
		for (int i = 0; i < 11; i++)
			f[95:88] ^= f[i*8 +: 8];
		f[95:88] ^= flip;
		for (int i = 0; i < n; i++)
		begin
			@(negedge i_clk);
			o_valid = 1'b1;
			o_data = f[i*8 +: 8];
			edge_wait(1'b0);
		end
		@(negedge i_clk);
		o_valid = 1'b0;
		o_data = ~o_data;
		o_tx_ready = (n == 12);
		for (int i = 0; i < 12 && n == 12; i++)
		begin
			if (i == 6)
			begin
				@(negedge i_clk);
				o_tx_ready = 1'b0;
				repeat (3) @(negedge i_clk);
				o_tx_ready = 1'b1;
			end
			edge_wait(1'b1);
			ans[i] = i_tx_data;
		end
		@(negedge i_clk);
		o_tx_ready = 1'b0;
	endtask
endmodule

// File: tb/testbench.sv
/*
 * Testbench of the frame engine: host model on both byte links, one task a scenario.
 * Assumes a 40 MHz clock and a shortened inter-byte timeout.
 */
`timescale 1ns/100ps
`include "fcp_defs.svh"
module testbench;
	import fcp_pkg::*;
	logic i_clk = 1'b0, i_rstn = 1'b0, rv, rr, tv, tr, drop;
	logic [7:0] rd, td;
	logic [11:0] vol;
	logic [31:0] v = 32'h0000_1234;
	logic [31:0] lst, rrt, pw, sh, er, es = 32'h0;
	logic [15:0] tof;
	logic [11:0] oc, um;
	logic cal;
	int errors = 0, tests_run = 0, drops = 0, cals = 0;
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) drops <= drops + (drop === 1'b1);
	always @(posedge i_clk) cals <= cals + (cal === 1'b1);
	fcp_frame_engine #(.TIMEOUT_CYCLES(20)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_rx_valid(rv), .i_rx_data(rd), .o_rx_ready(rr), .o_tx_valid(tv), .o_tx_data(td),
		.i_tx_ready(tr), .i_cpu_temp(v[15:0]), .i_dev_temp(v[15:0]), .i_vol_act(v[11:0]),
		.i_cur_val(v), .i_overcur_val(v), .i_dev_id(v), .i_err_set(es), .o_vol_set(vol),
		.o_lstat(lst), .o_reprate(rrt), .o_pulse_width(pw), .o_shots(sh), .o_overcur(oc),
		.o_temp_off(tof), .o_umin(um), .o_err(er), .o_cal_start(cal), .o_frame_drop(drop));
	fcp_host u_host (.i_clk(i_clk), .o_valid(rv), .o_data(rd), .i_ready(rr), .i_tx_valid(tv),
		.i_tx_data(td), .o_tx_ready(tr));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// Integrity sum over the 32-byte string store: serial at 0, name at 16.
	function automatic logic [63:0] rom_crc();
		logic [255:0] m;
		logic [15:0] c;
		m = {"FC0001", 80'h0, "PULSECTRL", 56'h0};
		c = `FCP_CRC_INIT;
		for (int a = 0; a < 32; a++)
		begin
			c ^= {m[255-8*a -: 8], 8'h00};
			for (int i = 0; i < 8; i++)
				c = c[15] ? ((c << 1) ^ `FCP_CRC_POLY) : (c << 1);
		end
		return {48'h0, c};
	endfunction
	task automatic run(input logic [15:0] c, input logic [63:0] p, input logic [15:0] rc,
		input logic [63:0] rp, input logic [7:0] flip);
		logic [7:0] x;
		logic [63:0] pr;
		u_host.xfer(c, p, flip, 12);
		x = 8'h00;
		for (int i = 0; i < 11; i++)
			x ^= u_host.ans[i];
		for (int i = 9; i > 1; i--)
			pr = {pr[55:0], u_host.ans[i]};
		check("code", {u_host.ans[1], u_host.ans[0]}, rc);
		check("param", pr, rp);
		check("trailer", {u_host.ans[10], u_host.ans[11]}, {8'h00, x});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_general();
		run(CMD_PING, 64'h0, RSP_PING, 64'h0, 8'h00);
		run(CMD_IDENT, 64'h0, RSP_IDENT, `FCP_DEVICE_ID, 8'h00);
		run(CMD_HW_VER, 64'h0, RSP_HW_VER, {40'h0, `FCP_HW_VERSION}, 8'h00);
		run(CMD_SW_VER, 64'h0, RSP_SW_VER, {40'h0, `FCP_SW_VERSION}, 8'h00);
		run(CMD_SERIAL, 64'h0, RSP_SERIAL, `FCP_SERIAL_LEN, 8'h00);
		run(CMD_SERIAL, 64'h1, RSP_SERIAL, 64'h46, 8'h00);
		run(CMD_SERIAL, 64'h7, RSP_BAD_PARAM, 64'h0, 8'h00);
		run(CMD_NAME, 64'h0, RSP_NAME, `FCP_NAME_LEN, 8'h00);
		run(CMD_NAME, 64'h1, RSP_NAME, 64'h50, 8'h00);
		run(Q_DEV_ID, 64'h0, RSP_DEV_ID, {32'h0, v}, 8'h00);
		run(Q_DEV_NAME, 64'h2, RSP_DEV_NAME, 64'h55, 8'h00);
		run(CMD_CRC, 64'h0, RSP_CRC, rom_crc(), 8'h00);
		$display("test general done");
	endtask
	task automatic t_faults();
		run(S_VOL, 64'h5, RSP_CKSUM_FAULT, 64'h0, 8'h01);
		check("vol", vol, 12'h000);
		run(16'h1234, 64'h0, RSP_UNKNOWN, 64'h0, 8'h00);
		run(16'hfe03, 64'h0, RSP_UNKNOWN, 64'h0, 8'h00);
		run(CMD_PING, 64'h1, RSP_BAD_PARAM, 64'h0, 8'h00);
		run(S_VOL, 64'hfff, RSP_VOLTAGE, 64'hfff, 8'h00);
		run(S_VOL, 64'h1000, RSP_BAD_PARAM, 64'h0, 8'h00);
		check("vol", vol, 12'hfff);
		run(Q_VOL_SET, 64'h0, RSP_VOLTAGE, 64'hfff, 8'h00);
		run(CMD_RESEND, 64'h0, RSP_VOLTAGE, 64'hfff, 8'h00);
		$display("test faults done");
	endtask
	task automatic t_gap();
		u_host.xfer(CMD_PING, 64'h0, 8'h00, 5);
		repeat (30) @(negedge i_clk);
		check("drop", drops, 1);
		run(CMD_PING, 64'h0, RSP_PING, 64'h0, 8'h00);
		$display("test gap done");
	endtask
	task automatic t_settings();
		run(S_PW, 64'h0, RSP_BAD_PARAM, 64'h0, 8'h00);
		run(S_PW, 64'h10, RSP_PW, 64'h10, 8'h00);
		run(S_RR, 64'h20, RSP_RR, 64'h20, 8'h00);
		run(S_SHOTS, 64'h3, RSP_SHOTS, 64'h3, 8'h00);
		run(S_OC, 64'h123, RSP_CURRENT, 64'h123, 8'h00);
		run(S_TEMP_OFF, 64'h65, RSP_BAD_PARAM, 64'h0, 8'h00);
		run(S_TEMP_OFF, 64'h40, RSP_TEMP, 64'h40, 8'h00);
		run(S_UMIN, 64'h77, RSP_VOLTAGE, 64'h77, 8'h00);
		run(S_LSTAT, 64'h5, RSP_LSTAT, 64'h5, 8'h00);
		check("pw", pw, 64'h10);
		check("reprate", rrt, 64'h20);
		check("shots", sh, 64'h3);
		check("overcur", oc, 64'h123);
		check("tempoff", tof, 64'h40);
		check("umin", um, 64'h77);
		check("lstat", lst, 64'h5);
		run(S_CAL, 64'h0, RSP_CAL, 64'h0, 8'h00);
		check("cal", cals, 1);
		@(negedge i_clk);
		es = 32'h0000_0001;
		@(negedge i_clk);
		es = 32'h0;
		check("err", er, 64'h1);
		run(S_CLR_ERR, 64'h0, RSP_CLR_ERR, 64'h0, 8'h00);
		check("err", er, 64'h0);
		run(S_DEFAULTS, 64'h0, RSP_DEFAULTS, 64'h0, 8'h00);
		check("pw", pw, `FCP_PW_RST);
		check("overcur", oc, `FCP_OC_RST);
		$display("test settings done");
	endtask
	task automatic t_reset();
		run(CMD_RESET, 64'h0, RSP_RESET, 64'h0, 8'h00);
		check("vol", vol, 12'h000);
		run(CMD_PING, 64'h0, RSP_PING, 64'h0, 8'h00);
		$display("test reset done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge i_clk);
		i_rstn = 1'b1;
		t_general();
		t_faults();
		t_gap();
		t_settings();
		t_reset();
		report_and_stop();
	end
endmodule
